// File: hdl/passive_parallel_config_load.v
//
// Behaviour
// RQ1: x8 ratio one, two with decompression
// RQ2: x16 ratio one, two secure, four decompressed
// RQ3: done low within 600 ns of request fall
// RQ4: status low within 600 ns of request fall
// RQ5: host holds request low at least 2 us
// RQ6: status low between 268 and 1506 us
// RQ7: status released within 1506 us after request rise
// RQ8: host waits 2 us after status rise
// RQ9: blind host waits 1506 us after request rise
// RQ10: internal oscillator init lasts 175 to 437 us
// RQ11: user init clock starts four clocks after done
// RQ12: user clock init waits 8576 clock edges
// RQ13: request fall in user mode restarts configuration
// RQ14: done low from power-up through configuration
// RQ15: host holds data N-1 clocks after edge
// RQ16: capture word on edge, next after ratio edges
`timescale 1ns/100ps
`include "passive_parallel_consts.vh"

module passive_parallel_config_load #(
  parameter DATA_W = 32,
  parameter CNT_W = 20,
  parameter STATUS_LOW_MIN_CYC = `STATUS_LOW_MIN_CYC,
  parameter INIT_MIN_CYC = `INIT_MIN_CYC,
  parameter USER_INIT_EDGES = `USER_INIT_EDGES
) (
  input wire core_clk,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [4:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cfgRequest_n,
  input wire statusIn_n,
  output reg statusOut_n,
  output reg statusOe,
  output reg confDone,
  input wire config_clock,
  input wire user_init_clock,
  input wire [DATA_W-1:0] cfgData,
  output reg userMode,
  output reg irq
);

  localparam NPIN = DATA_W + 4;
  localparam ST_LOW = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_INIT = 2'h2;
  localparam ST_USER = 2'h3;

  // three-stage synchronisers; a level is taken once stages two and three agree
  wire [NPIN-1:0] pinRaw;
  reg [NPIN-1:0] s1_q;
  reg [NPIN-1:0] s2_q;
  reg [NPIN-1:0] s3_q;
  reg [NPIN-1:0] pin_q;
  assign pinRaw = {cfgData, user_init_clock, config_clock, statusIn_n, cfgRequest_n};

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gSync
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pinRaw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  reg reqPrev_q;
  reg cclkPrev_q;
  reg uclkPrev_q;
  wire reqLevel = pin_q[0];
  wire extStatus = pin_q[1];
  wire cclkRise = pin_q[2] & ~cclkPrev_q;
  wire uclkRise = pin_q[3] & ~uclkPrev_q;
  wire reqFall = ~reqLevel & reqPrev_q;
  wire [DATA_W-1:0] dataLevel = pin_q[NPIN-1:4];

  // registers
  reg [4:0] ctrl_q;
  reg [31:0] len_q;
  reg [31:0] words_q;
  reg [DATA_W-1:0] lastWord_q;
  reg [`IRQ_W-1:0] irqStat_q;
  reg [`IRQ_W-1:0] irqMask_q;
  reg [1:0] state_q;
  reg [CNT_W-1:0] timer_q;
  reg [2:0] phase_q;
  reg [2:0] ratioM1;

  wire [1:0] widthSel = ctrl_q[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO];
  wire decompOn = ctrl_q[`CTRL_DECOMP];
  wire secureOn = ctrl_q[`CTRL_SECURE];
  wire userClkOn = ctrl_q[`CTRL_USERCLK];

  // edges per word, minus one
  always @* begin
    if (widthSel == `WIDTH_X8) begin
      ratioM1 = decompOn ? 3'h1 : 3'h0; // [RQ1]
    end else begin
      // wider buses follow the x16 ratios
      if (decompOn) begin
        ratioM1 = 3'h3; // [RQ2]
      end else begin
        ratioM1 = secureOn ? 3'h1 : 3'h0; // [RQ2]
      end
    end
  end

  // apb: one wait state, so pready comes from a flip-flop
  wire access = psel & penable;
  wire done = access & pready;
  wire wrDone = done & pwrite;
  wire rdIrqDone = done & ~pwrite & (paddr == `REG_IRQ);
  reg [31:0] rdMux;
  reg rdErr;

  always @* begin
    rdMux = 32'h0000_0000;
    rdErr = 1'b0;
    case (paddr)
      `REG_CTRL: rdMux = {27'h0000000, ctrl_q};
      `REG_LEN: rdMux = len_q;
      `REG_STATE: rdMux = {27'h0000000, userMode, confDone, statusOe, state_q};
      `REG_WORDS: rdMux = words_q;
      `REG_DATA: rdMux[DATA_W-1:0] = lastWord_q;
      `REG_IRQ: rdMux = {29'h00000000, irqStat_q};
      `REG_MASK: rdMux = {29'h00000000, irqMask_q};
      default: rdErr = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      len_q <= 32'h0000_0000;
      irqMask_q <= 3'h0;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= rdErr;
      end else if (done) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
      if (wrDone) begin
        case (paddr)
          `REG_CTRL: ctrl_q <= pwdata[4:0];
          `REG_LEN: len_q <= pwdata;
          `REG_MASK: irqMask_q <= pwdata[`IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // configuration sequencer
  reg [`IRQ_W-1:0] evt;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqPrev_q <= 1'b0;
      cclkPrev_q <= 1'b0;
      uclkPrev_q <= 1'b0;
      state_q <= ST_LOW;
      timer_q <= {CNT_W{1'b0}};
      phase_q <= 3'h0;
      words_q <= 32'h0000_0000;
      lastWord_q <= {DATA_W{1'b0}};
      statusOut_n <= 1'b0;
      statusOe <= 1'b1;
      confDone <= 1'b0; // [RQ14]
      userMode <= 1'b0;
      evt <= 3'h0;
    end else begin
      reqPrev_q <= reqLevel;
      cclkPrev_q <= pin_q[2];
      uclkPrev_q <= pin_q[3];
      statusOut_n <= 1'b0;
      evt <= 3'h0;
      if (reqFall) begin
        // sync plus one cycle stays far below the 600 ns bound
        state_q <= ST_LOW; // [RQ13]
        statusOe <= 1'b1; // [RQ4]
        confDone <= 1'b0; // [RQ3]
        userMode <= 1'b0;
        timer_q <= {CNT_W{1'b0}};
        evt[`IRQ_START] <= 1'b1;
      end else begin
        case (state_q)
          ST_LOW: begin
            if (timer_q < STATUS_LOW_MIN_CYC[CNT_W-1:0]) begin
              timer_q <= timer_q + 1'b1;
            end else if (reqLevel) begin
              // released as soon as both the least time and a high request are seen
              statusOe <= 1'b0; // [RQ6] [RQ7]
              state_q <= ST_LOAD;
              phase_q <= 3'h0;
              words_q <= 32'h0000_0000;
            end
          end
          ST_LOAD: begin
            // an external low on status stalls loading; the host is expected to wait
            if (cclkRise & extStatus) begin // [RQ8] [RQ9]
              if (phase_q == 3'h0) begin
                lastWord_q <= dataLevel; // [RQ16] [RQ15]
                words_q <= words_q + 32'h0000_0001;
              end
              phase_q <= (phase_q == ratioM1) ? 3'h0 : phase_q + 3'h1; // [RQ16]
            end
            if (len_q != 32'h0000_0000 && words_q == len_q && phase_q == 3'h0) begin
              confDone <= 1'b1;
              state_q <= ST_INIT;
              timer_q <= {CNT_W{1'b0}};
              evt[`IRQ_LOADED] <= 1'b1;
            end
          end
          ST_INIT: begin
            if (userClkOn) begin
              // host starts the init clock late enough; only its rising edges count
              if (uclkRise) begin // [RQ11]
                timer_q <= timer_q + 1'b1;
              end
              if (timer_q >= USER_INIT_EDGES[CNT_W-1:0]) begin // [RQ12]
                state_q <= ST_USER;
                userMode <= 1'b1;
                evt[`IRQ_USER] <= 1'b1;
              end
            end else begin
              timer_q <= timer_q + 1'b1;
              if (timer_q >= INIT_MIN_CYC[CNT_W-1:0]) begin // [RQ10]
                state_q <= ST_USER;
                userMode <= 1'b1;
                evt[`IRQ_USER] <= 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sticky status, cleared by reading it; a new event wins over the clear
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~(rdIrqDone ? prdata[`IRQ_W-1:0] : 3'h0)) | evt;
      irq <= |(irqStat_q & irqMask_q);
    end
  end

endmodule // passive_parallel_config_load

// File: hdl/passive_parallel_consts.vh
`ifndef PASSIVE_PARALLEL_CONSTS_VH
`define PASSIVE_PARALLEL_CONSTS_VH

// register byte offsets
`define REG_CTRL 5'h00
`define REG_LEN 5'h04
`define REG_STATE 5'h08
`define REG_WORDS 5'h0c
`define REG_DATA 5'h10
`define REG_IRQ 5'h14
`define REG_MASK 5'h18

// control fields
`define CTRL_WIDTH_LO 0
`define CTRL_WIDTH_HI 1
`define CTRL_DECOMP 2
`define CTRL_SECURE 3
`define CTRL_USERCLK 4
`define CTRL_RESET 5'h00

// bus width codes
`define WIDTH_X8 2'h0
`define WIDTH_X16 2'h1
`define WIDTH_X32 2'h2

// interrupt bits
`define IRQ_START 0
`define IRQ_LOADED 1
`define IRQ_USER 2
`define IRQ_W 3

// timing
`define CLK_PERIOD_NS 8
`define REQ_TO_LOW_MAX_NS 600
`define STATUS_LOW_MIN_US 268
`define STATUS_LOW_MAX_US 1506
`define INIT_MIN_US 175
`define INIT_MAX_US 437
`define USER_INIT_EDGES 8576
// least times round up, longest times round down
`define REQ_TO_LOW_MAX_CYC (`REQ_TO_LOW_MAX_NS / `CLK_PERIOD_NS)
`define STATUS_LOW_MIN_CYC ((`STATUS_LOW_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_MIN_CYC ((`INIT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: verif/cfg_host.sv
`timescale 1ns/100ps
module cfg_host (
  output logic config_clock,
  output logic [31:0] cfgData
);
  initial begin
    config_clock = 1'b0;
    cfgData = 32'h0;
  end
  // clock stands low outside frames; data changes only after a falling edge
  task automatic send(input int n, input int ratio, input logic [31:0] base);
    #2;
    for (int w = 0; w < n; w++) begin
      cfgData = base + w;
      for (int c = 0; c < ratio; c++) begin
        #62.5 config_clock = 1'b1;
        #62.5 config_clock = 1'b0;
      end
    end
    cfgData = ~cfgData;
  endtask
endmodule // cfg_host

// File: verif/passive_parallel_config_load_assertions.sv
`timescale 1ns/100ps
module passive_parallel_config_load_assertions #(
  parameter STATUS_LOW_MIN_CYC = 50,
  parameter INIT_MIN_CYC = 40
) (
  input wire core_clk,
  input wire arst_n,
  input wire cfgRequest_n,
  input wire statusOe,
  input wire confDone,
  input wire userMode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [19:0] lowCnt_q, initCnt_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt_q <= 20'h0;
      initCnt_q <= 20'h0;
    end else begin
      lowCnt_q <= statusOe ? lowCnt_q + 20'h1 : 20'h0;
      initCnt_q <= (confDone && !userMode) ? initCnt_q + 20'h1 : 20'h0;
    end
  end
  a_done_drops: assert property ($fell(cfgRequest_n) |-> ##[0:74] !confDone) else $error("done late");
  a_status_pulls: assert property ($fell(cfgRequest_n) |-> ##[0:74] statusOe) else $error("pull late");
  a_status_min: assert property ($fell(statusOe) |-> lowCnt_q >= STATUS_LOW_MIN_CYC - 1) else $error("short");
  a_status_frees: assert property (statusOe && cfgRequest_n && lowCnt_q > STATUS_LOW_MIN_CYC + 8
    |-> ##[0:8] !statusOe) else $error("not released");
  a_init_min: assert property ($rose(userMode) |-> initCnt_q >= INIT_MIN_CYC - 1) else $error("init short");
  a_user_after: assert property ($rose(userMode) |-> confDone && $past(confDone, 8)) else $error("early");
  a_user_restart: assert property (userMode && $fell(cfgRequest_n) |-> ##[1:74] !userMode) else $error("stuck");
  a_done_held: assert property (statusOe && $past(statusOe, 3) |-> !confDone) else $error("done high");
endmodule // passive_parallel_config_load_assertions

bind passive_parallel_config_load passive_parallel_config_load_assertions #(
  .STATUS_LOW_MIN_CYC(STATUS_LOW_MIN_CYC),
  .INIT_MIN_CYC(INIT_MIN_CYC)
) props (.core_clk, .arst_n, .cfgRequest_n, .statusOe, .confDone, .userMode);

// File: verif/passive_parallel_config_load_tb_top.sv
`timescale 1ns/100ps
`include "passive_parallel_consts.vh"
module passive_parallel_config_load_tb_top;
  logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cfgRequest_n = 1'b1, uclk = 1'b0, pready, pslverr, statusOe, confDone, userMode, irq, cfgClk, e, sOut_n;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0, prdata, cfgData, r;
  wire statusIn_n = ~statusOe;
  int fails = 0, checked = 0;
  logic [4:0] ctl [9] = '{5'h00, 5'h08, 5'h04, 5'h0c, 5'h01, 5'h09, 5'h05, 5'h0d, 5'h12};
  int rat [9] = '{1, 1, 2, 2, 1, 2, 4, 4, 1};
  always #4 core_clk = ~core_clk;
  passive_parallel_config_load #(.STATUS_LOW_MIN_CYC(50), .INIT_MIN_CYC(40), .USER_INIT_EDGES(4)) dut (
    .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfgRequest_n,
    .statusIn_n, .statusOut_n(sOut_n), .statusOe, .confDone, .config_clock(cfgClk), .user_init_clock(uclk),
    .cfgData, .userMode, .irq);
  cfg_host host (.config_clock(cfgClk), .cfgData);
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge core_clk);
    if (i == 16) begin
      fails++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // bounded wait; a hang is counted and ends the run
  task automatic waitSt(input int s, input logic v);
    int i;
    for (i = 0; i < 3000 && (s == 0 ? statusOe : s == 1 ? confDone : userMode) !== v; i++) @(posedge core_clk);
    if (i == 3000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    waitSt(0, 1'b0);
    apb(1'b0, `REG_IRQ, 32'h0);
    apb(1'b1, `REG_LEN, 32'h3);
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, `REG_CTRL, {27'h0, ctl[k]});
      apb(1'b1, `REG_MASK, k < 8 ? 32'h7 : 32'h0);
      cfgRequest_n <= 1'b0;
      repeat (250) @(posedge core_clk);
      chk({statusOe, confDone, userMode}, 3'b100);
      chk(sOut_n, 1'b0);
      apb(1'b0, `REG_CTRL, 32'h0);
      chk(r, {27'h0, ctl[k]});
      cfgRequest_n <= 1'b1;
      waitSt(0, 1'b0);
      repeat (250) @(posedge core_clk);
      host.send(3, rat[k], 32'ha0 * k);
      waitSt(1, 1'b1);
      apb(1'b0, `REG_WORDS, 32'h0);
      chk(r, 32'h3);
      apb(1'b0, `REG_DATA, 32'h0);
      chk(r, 32'ha0 * k + 2);
      if (ctl[k][4]) begin
        repeat (100) @(posedge core_clk);
        chk(userMode, 1'b0);
        repeat (8) begin
          repeat (8) @(posedge core_clk);
          uclk <= ~uclk;
        end
      end
      waitSt(2, 1'b1);
      repeat (2) @(posedge core_clk);
      chk(irq, k < 8);
      apb(1'b0, `REG_STATE, 32'h0);
      chk(r, 32'h1b);
      apb(1'b0, `REG_IRQ, 32'h0);
      chk(r, 32'h7);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'b0);
    end
    apb(1'b0, 5'h1c, 32'h0);
    chk(e, 1'b1);
    tally_and_finish();
  end
endmodule // passive_parallel_config_load_tb_top
